// *** hdl/ccp_pkg.sv ***
// shared constants of the raster display timing controller
package ccp_pkg;
  localparam int REG_CNT = 20;
  localparam logic [4:0] IDX_HTOT = 5'h00;
  localparam logic [4:0] IDX_HDISP = 5'h01;
  localparam logic [4:0] IDX_HSPOS = 5'h02;
  localparam logic [4:0] IDX_SYNCW = 5'h03;
  localparam logic [4:0] IDX_VTOT = 5'h04;
  localparam logic [4:0] IDX_VADJ = 5'h05;
  localparam logic [4:0] IDX_VDISP = 5'h06;
  localparam logic [4:0] IDX_VSPOS = 5'h07;
  localparam logic [4:0] IDX_MODE = 5'h08;
  localparam logic [4:0] IDX_LINES = 5'h09;
  localparam logic [4:0] IDX_CSTART = 5'h0A;
  localparam logic [4:0] IDX_CEND = 5'h0B;
  localparam logic [4:0] IDX_STARTH = 5'h0C;
  localparam logic [4:0] IDX_STARTL = 5'h0D;
  localparam logic [4:0] IDX_CURH = 5'h0E;
  localparam logic [4:0] IDX_CURL = 5'h0F;
  localparam logic [4:0] IDX_LPENH = 5'h10;
  localparam logic [4:0] IDX_LPENL = 5'h11;
  localparam logic [4:0] IDX_UPDH = 5'h12;
  localparam logic [4:0] IDX_UPDL = 5'h13;
  localparam logic [4:0] IDX_DUMMY = 5'h1F;
  // mode control field positions
  localparam int MODE_ROWCOL = 2;
  localparam int MODE_TRANSP = 3;
  localparam int MODE_DE_DLY = 4;
  localparam int MODE_CUR_DLY = 5;
  // scan status field positions
  localparam int STAT_VBLANK = 5;
  localparam int STAT_LPFULL = 6;
  localparam int STAT_UPDRDY = 7;
  // cursor mode field in cursor start register
  localparam logic [1:0] CUR_OFF = 2'h1;
  localparam logic [1:0] CUR_BLINK16 = 2'h2;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [4:0] PTR_RST = 5'h00;
  localparam logic [13:0] LIGHT_PEN_STROBE_AHEAD = 14'h0002;
  localparam logic [4:0] VSYNC_ZERO_W = 5'h10;
endpackage : ccp_pkg

// *** hdl/ccp_hbus_if.sv ***
// register transfer signals between host port and timing core
`timescale 1ns/10ps
interface ccp_hbus_if;
  logic wr_stb;
  logic rd_stb;
  logic rs;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rdrive;
  modport port (output wr_stb, output rd_stb, output rs, output wdata,
                input rdata, input rdrive);
  modport core (input wr_stb, input rd_stb, input rs, input wdata,
                output rdata, output rdrive);
endinterface : ccp_hbus_if

// *** hdl/ccp_host_port.sv ***
// host bus port: pin synchronisers, transfer strobes, data bus drive
`timescale 1ns/10ps
module ccp_host_port (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic phi2_i, // host bus clock pin
  input wire logic cs_n_i, // chip select, active low
  input wire logic register_select_i, // low: pointer/status, high: data reg
  input wire logic rw_i, // high read, low write
  input wire logic [7:0] host_data_lines_i, // data bus in
  output logic [7:0] host_data_lines_o, // data bus out
  output logic host_data_lines_oe_o, // data bus drive enable
  ccp_hbus_if.port bus // transfer strobes to the core
);
  logic [11:0] meta_r;
  logic [11:0] sync_r;
  logic phi2_d_r;
  logic phi2_s, cs_n_s, rs_s, rw_s;
  logic [7:0] dat_s;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= 12'h002;
      sync_r <= 12'h002;
    end else begin
      meta_r <= {host_data_lines_i, rw_i, register_select_i, cs_n_i, phi2_i};
      sync_r <= meta_r;
    end
  end

  assign phi2_s = sync_r[0];
  assign cs_n_s = sync_r[1];
  assign rs_s = sync_r[2];
  assign rw_s = sync_r[3];
  assign dat_s = sync_r[11:4];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phi2_d_r <= 1'b0;
    end else begin
      phi2_d_r <= phi2_s;
    end
  end

  // a transfer commits on the falling edge of the host clock, so a stopped
  // clock simply holds the bus cycle open
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      bus.wdata <= 8'h00;
    end else begin
      bus.wr_stb <= phi2_d_r && !phi2_s && !cs_n_s && !rw_s;
      bus.rd_stb <= phi2_d_r && !phi2_s && !cs_n_s && rw_s;
      bus.wdata <= dat_s;
    end
  end

  assign bus.rs = rs_s;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      host_data_lines_o <= 8'h00;
      host_data_lines_oe_o <= 1'b0;
    end else begin
      host_data_lines_o <= bus.rdata;
      host_data_lines_oe_o <= phi2_s && !cs_n_s && rw_s && bus.rdrive;
    end
  end
endmodule : ccp_host_port

// *** hdl/ccp_crt_core.sv ***
// raster timing core: registers, scan counters, video outputs
`timescale 1ns/10ps
module ccp_crt_core (
  input wire logic ref_clk_i, // 50 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic phi2_i, // host bus clock pin
  input wire logic cs_n_i, // chip select, active low
  input wire logic register_select_i, // register select
  input wire logic rw_i, // high read, low write
  input wire logic [7:0] host_data_lines_i, // data bus in
  output logic [7:0] host_data_lines_o, // data bus out
  output logic host_data_lines_oe_o, // data bus drive enable
  input wire logic character_clock_i, // character clock pin
  input wire logic scan_reset_n_i, // scan reset pin, active low
  input wire logic light_pen_strobe_i, // light pen pin
  output logic hsync_o, // horizontal sync
  output logic vsync_o, // vertical sync
  output logic disp_en_o, // display enable
  output logic cursor_o, // cursor
  output logic [13:0] video_mem_addr_o, // video memory address
  output logic [4:0] raster_line_addr_o // raster line, top bit may strobe
);
  ccp_hbus_if hb ();

  ccp_host_port u_port (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .phi2_i(phi2_i),
    .cs_n_i(cs_n_i),
    .register_select_i(register_select_i),
    .rw_i(rw_i),
    .host_data_lines_i(host_data_lines_i),
    .host_data_lines_o(host_data_lines_o),
    .host_data_lines_oe_o(host_data_lines_oe_o),
    .bus(hb.port)
  );

  function automatic logic [7:0] reg_mask(input logic [4:0] idx);
    unique case (idx)
      ccp_pkg::IDX_VTOT, ccp_pkg::IDX_VDISP, ccp_pkg::IDX_VSPOS,
      ccp_pkg::IDX_CSTART: reg_mask = 8'h7F;
      ccp_pkg::IDX_VADJ, ccp_pkg::IDX_LINES, ccp_pkg::IDX_CEND: reg_mask = 8'h1F;
      ccp_pkg::IDX_STARTH, ccp_pkg::IDX_CURH, ccp_pkg::IDX_UPDH: reg_mask = 8'h3F;
      default: reg_mask = 8'hFF;
    endcase
  endfunction : reg_mask

  // ---------------- character side pin synchronisers ----------------
  logic [2:0] cmeta_r;
  logic [2:0] csync_r;
  logic character_clock_d_r;
  logic light_pen_strobe_d_r;
  logic tick;
  logic run;
  logic light_pen_strobe_rise;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmeta_r <= 3'h0;
      csync_r <= 3'h0;
      character_clock_d_r <= 1'b0;
      light_pen_strobe_d_r <= 1'b0;
    end else begin
      cmeta_r <= {light_pen_strobe_i, scan_reset_n_i, character_clock_i};
      csync_r <= cmeta_r;
      character_clock_d_r <= csync_r[0];
      light_pen_strobe_d_r <= csync_r[2];
    end
  end

  assign tick = csync_r[0] && !character_clock_d_r;
  assign run = csync_r[1];
  assign light_pen_strobe_rise = csync_r[2] && !light_pen_strobe_d_r;

  // ---------------- register file ----------------
  logic [7:0] regs_r [0:ccp_pkg::REG_CNT-1];
  logic [4:0] ptr_r;
  logic [13:0] upd_addr_r;
  logic [13:0] light_pen_strobe_addr_r;
  logic lp_full_r, upd_rdy_r, upd_pend_r;
  logic vblank_r;
  logic upd_stb;
  logic sel_wr, sel_rd, dummy_hit, light_pen_strobe_rd;

  assign sel_wr = hb.wr_stb && hb.rs;
  assign sel_rd = hb.rd_stb && hb.rs;
  assign dummy_hit = (sel_wr || sel_rd) && (ptr_r == ccp_pkg::IDX_DUMMY);
  assign light_pen_strobe_rd = sel_rd && (ptr_r == ccp_pkg::IDX_LPENH || ptr_r == ccp_pkg::IDX_LPENL);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_r <= ccp_pkg::PTR_RST;
    end else if (hb.wr_stb && !hb.rs) begin
      ptr_r <= hb.wdata[4:0];
    end
  end

  // control registers are reset only by the system reset, never by scan reset
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < ccp_pkg::REG_CNT; i++) begin
        regs_r[i] <= ccp_pkg::REG_RST;
      end
    end else if (sel_wr && ptr_r < ccp_pkg::IDX_LPENH) begin
      regs_r[ptr_r] <= hb.wdata & reg_mask(ptr_r);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_addr_r <= 14'h0000;
    end else if (sel_wr && ptr_r == ccp_pkg::IDX_UPDH) begin
      upd_addr_r[13:8] <= hb.wdata[5:0];
    end else if (sel_wr && ptr_r == ccp_pkg::IDX_UPDL) begin
      upd_addr_r[7:0] <= hb.wdata;
    end else if (upd_stb) begin
      upd_addr_r <= upd_addr_r + 14'h0001;
    end
  end

  always_comb begin
    hb.rdrive = !hb.rs || (ptr_r != ccp_pkg::IDX_DUMMY);
    hb.rdata = 8'h00;
    if (!hb.rs) begin
      hb.rdata[ccp_pkg::STAT_VBLANK] = vblank_r;
      hb.rdata[ccp_pkg::STAT_LPFULL] = lp_full_r;
      hb.rdata[ccp_pkg::STAT_UPDRDY] = upd_rdy_r;
    end else begin
      unique case (ptr_r)
        ccp_pkg::IDX_CURH: hb.rdata = regs_r[ccp_pkg::IDX_CURH];
        ccp_pkg::IDX_CURL: hb.rdata = regs_r[ccp_pkg::IDX_CURL];
        ccp_pkg::IDX_LPENH: hb.rdata = {2'b00, light_pen_strobe_addr_r[13:8]};
        ccp_pkg::IDX_LPENL: hb.rdata = light_pen_strobe_addr_r[7:0];
        default: hb.rdata = 8'h00;
      endcase
    end
  end

  // flags: both sides run on the system clock after synchronisation, and a
  // set in the same cycle as a clear wins so no event is lost
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp_full_r <= 1'b0;
    end else if (light_pen_strobe_rise && run) begin
      lp_full_r <= 1'b1;
    end else if (light_pen_strobe_rd) begin
      lp_full_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_rdy_r <= 1'b0;
    end else if (upd_stb) begin
      upd_rdy_r <= 1'b1;
    end else if (dummy_hit) begin
      upd_rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      upd_pend_r <= 1'b0;
    end else if (dummy_hit) begin
      upd_pend_r <= 1'b1;
    end else if (upd_stb) begin
      upd_pend_r <= 1'b0;
    end
  end

  // ---------------- scan counters ----------------
  logic [7:0] h_r;
  logic [4:0] line_r;
  logic [6:0] row_r;
  logic [4:0] adj_r;
  logic in_adj_r;
  logic [13:0] ma_r, row_start_r;
  logic [4:0] vs_cnt_r;
  logic [4:0] field_r;
  logic [13:0] start_addr, cur_addr;
  logic h_end, l_end, r_end, f_end;

  assign start_addr = {regs_r[ccp_pkg::IDX_STARTH][5:0], regs_r[ccp_pkg::IDX_STARTL]};
  assign cur_addr = {regs_r[ccp_pkg::IDX_CURH][5:0], regs_r[ccp_pkg::IDX_CURL]};
  assign h_end = h_r == regs_r[ccp_pkg::IDX_HTOT];
  assign l_end = line_r == regs_r[ccp_pkg::IDX_LINES][4:0];
  assign r_end = !in_adj_r && row_r == regs_r[ccp_pkg::IDX_VTOT][6:0];
  assign f_end = in_adj_r ? (adj_r == regs_r[ccp_pkg::IDX_VADJ][4:0])
                          : (l_end && r_end && regs_r[ccp_pkg::IDX_VADJ][4:0] == 5'h00);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_r <= 8'h00;
      line_r <= 5'h00;
      row_r <= 7'h00;
      adj_r <= 5'h00;
      in_adj_r <= 1'b0;
      field_r <= 5'h00;
    end else if (!run) begin
      h_r <= 8'h00;
      line_r <= 5'h00;
      row_r <= 7'h00;
      adj_r <= 5'h00;
      in_adj_r <= 1'b0;
    end else if (tick) begin
      h_r <= h_end ? 8'h00 : h_r + 8'h01;
      if (h_end) begin
        if (f_end) begin
          line_r <= 5'h00;
          row_r <= 7'h00;
          adj_r <= 5'h00;
          in_adj_r <= 1'b0;
          field_r <= field_r + 5'h01;
        end else if (in_adj_r) begin
          adj_r <= adj_r + 5'h01;
        end else if (l_end) begin
          line_r <= 5'h00;
          if (r_end) begin
            in_adj_r <= 1'b1;
            adj_r <= 5'h01;
          end else begin
            row_r <= row_r + 7'h01;
          end
        end else begin
          line_r <= line_r + 5'h01;
        end
      end
    end
  end

  // address counter restarts each line at the row start address
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ma_r <= 14'h0000;
      row_start_r <= 14'h0000;
    end else if (!run) begin
      ma_r <= start_addr;
      row_start_r <= start_addr;
    end else if (tick) begin
      if (h_end && f_end) begin
        ma_r <= start_addr;
        row_start_r <= start_addr;
      end else if (h_end && l_end && !in_adj_r) begin
        ma_r <= row_start_r + {6'h00, regs_r[ccp_pkg::IDX_HDISP]};
        row_start_r <= row_start_r + {6'h00, regs_r[ccp_pkg::IDX_HDISP]};
      end else if (h_end) begin
        ma_r <= row_start_r;
      end else begin
        ma_r <= ma_r + 14'h0001;
      end
    end
  end

  // vertical sync width counts scan lines; a width of zero means sixteen
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vs_cnt_r <= 5'h00;
    end else if (!run) begin
      vs_cnt_r <= 5'h00;
    end else if (tick && h_end) begin
      if (!in_adj_r && l_end && !r_end &&
          row_r + 7'h01 == regs_r[ccp_pkg::IDX_VSPOS][6:0]) begin
        vs_cnt_r <= (regs_r[ccp_pkg::IDX_SYNCW][7:4] == 4'h0) ? ccp_pkg::VSYNC_ZERO_W
                    : {1'b0, regs_r[ccp_pkg::IDX_SYNCW][7:4]};
      end else if (vs_cnt_r != 5'h00) begin
        vs_cnt_r <= vs_cnt_r - 5'h01;
      end
    end
  end

  // ---------------- output stage ----------------
  logic [7:0] h_rel;
  logic de_now, cur_now, hs_now, blink_ok, upd_now;
  logic de_prev_r, cur_prev_r;
  logic [7:0] mode;

  assign mode = regs_r[ccp_pkg::IDX_MODE];
  assign h_rel = h_r - regs_r[ccp_pkg::IDX_HSPOS];
  assign hs_now = h_r >= regs_r[ccp_pkg::IDX_HSPOS] &&
                  h_rel < {4'h0, regs_r[ccp_pkg::IDX_SYNCW][3:0]};
  assign de_now = h_r < regs_r[ccp_pkg::IDX_HDISP] && !in_adj_r &&
                  row_r < regs_r[ccp_pkg::IDX_VDISP][6:0];
  assign upd_now = mode[ccp_pkg::MODE_TRANSP] && upd_pend_r &&
                   h_r == regs_r[ccp_pkg::IDX_HDISP];
  assign upd_stb = run && tick && upd_now;

  always_comb begin
    unique case (regs_r[ccp_pkg::IDX_CSTART][6:5])
      2'h0: blink_ok = 1'b1;
      ccp_pkg::CUR_OFF: blink_ok = 1'b0;
      ccp_pkg::CUR_BLINK16: blink_ok = field_r[ccp_pkg::BLINK16_BIT];
      default: blink_ok = field_r[ccp_pkg::BLINK32_BIT];
    endcase
  end

  assign cur_now = blink_ok && de_now && ma_r == cur_addr &&
                   line_r >= regs_r[ccp_pkg::IDX_CSTART][4:0] &&
                   line_r <= regs_r[ccp_pkg::IDX_CEND][4:0];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      disp_en_o <= 1'b0;
      cursor_o <= 1'b0;
      de_prev_r <= 1'b0;
      cur_prev_r <= 1'b0;
      video_mem_addr_o <= 14'h0000;
      raster_line_addr_o <= 5'h00;
    end else if (!run) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      disp_en_o <= 1'b0;
      cursor_o <= 1'b0;
      de_prev_r <= 1'b0;
      cur_prev_r <= 1'b0;
      video_mem_addr_o <= 14'h0000;
      raster_line_addr_o <= 5'h00;
    end else if (tick) begin
      hsync_o <= hs_now;
      // the width counter loads on the last tick of the row before, so it alone
      // frames the pulse; an extra start term would widen it by one character
      vsync_o <= vs_cnt_r != 5'h00;
      de_prev_r <= de_now;
      cur_prev_r <= cur_now;
      disp_en_o <= mode[ccp_pkg::MODE_DE_DLY] ? de_prev_r : de_now;
      cursor_o <= mode[ccp_pkg::MODE_CUR_DLY] ? cur_prev_r : cur_now;
      if (upd_now) begin
        video_mem_addr_o <= upd_addr_r;
      end else if (mode[ccp_pkg::MODE_ROWCOL]) begin
        video_mem_addr_o <= {row_r[5:0], h_r};
      end else begin
        video_mem_addr_o <= ma_r;
      end
      raster_line_addr_o[3:0] <= line_r[3:0];
      raster_line_addr_o[4] <= mode[ccp_pkg::MODE_TRANSP] ? upd_now : line_r[4];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vblank_r <= 1'b0;
    end else begin
      vblank_r <= run && (in_adj_r || row_r >= regs_r[ccp_pkg::IDX_VDISP][6:0]);
    end
  end

  // pen edge is taken against the running counter, two characters ahead
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      light_pen_strobe_addr_r <= 14'h0000;
    end else if (light_pen_strobe_rise && run) begin
      light_pen_strobe_addr_r <= ma_r + ccp_pkg::LIGHT_PEN_STROBE_AHEAD;
    end
  end
endmodule : ccp_crt_core

// *** sim/ccp_crt_checker.sv ***
// concurrent checks on the timing controller ports
`timescale 1ns/10ps
module ccp_crt_checker (
  input wire logic ref_clk_i, // clk
  input wire logic rst_b_i, // reset
  input wire logic phi2_i, // bus clk
  input wire logic cs_n_i, // select
  input wire logic register_select_i, // rs
  input wire logic rw_i, // dir
  input wire logic [7:0] host_data_lines_o, // bus out
  input wire logic host_data_lines_oe_o, // bus en
  input wire logic character_clock_i, // char clk
  input wire logic scan_reset_n_i, // scan rst
  input wire logic hsync_o, // hs
  input wire logic vsync_o, // vs
  input wire logic disp_en_o, // de
  input wire logic cursor_o, // cursor
  input wire logic [13:0] video_mem_addr_o, // ma
  input wire logic [4:0] raster_line_addr_o // ra
);
  logic cc_q_r;
  logic [3:0] since_r;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ref clocks since the last character clock rise, saturating
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cc_q_r <= 1'b0;
      since_r <= 4'hF;
    end else begin
      cc_q_r <= character_clock_i;
      if (character_clock_i && !cc_q_r)
        since_r <= 4'h0;
      else if (since_r != 4'hF)
        since_r <= since_r + 4'h1;
    end
  end
  a_float_desel: assert property (cs_n_i [*5] |-> !host_data_lines_oe_o)
    else $error("bus driven while deselected");
  a_float_write: assert property (!rw_i [*5] |-> !host_data_lines_oe_o)
    else $error("bus driven in a write");
  a_oe_cause: assert property ($rose(host_data_lines_oe_o) |->
    !$past(cs_n_i, 2) && $past(rw_i, 2) && $past(phi2_i, 2))
    else $error("bus drive without a selected read");
  a_read_holds: assert property
    ((!cs_n_i && rw_i && phi2_i && host_data_lines_oe_o) [*2] |=> host_data_lines_oe_o)
    else $error("read data withdrawn early");
  a_status_zero: assert property (host_data_lines_oe_o && !register_select_i &&
    !$past(register_select_i, 5) |-> host_data_lines_o[4:0] == 5'h00)
    else $error("unused status bits not zero");
  a_scan_idle_low: assert property (!scan_reset_n_i [*5] |->
    {hsync_o, vsync_o, disp_en_o, cursor_o, video_mem_addr_o, raster_line_addr_o} == 23'h000000)
    else $error("scan output active in scan reset");
  a_addr_on_tick: assert property ($changed(video_mem_addr_o) && scan_reset_n_i &&
    $past(scan_reset_n_i, 5) |-> since_r >= 4'h1 && since_r <= 4'h6)
    else $error("address moved off a character tick");
  a_sync_on_tick: assert property ($changed({hsync_o, vsync_o, disp_en_o, cursor_o}) &&
    scan_reset_n_i && $past(scan_reset_n_i, 5) |-> since_r >= 4'h1 && since_r <= 4'h6)
    else $error("video output moved off a character tick");
  a_hsync_whole: assert property ($fell(hsync_o) && $past(scan_reset_n_i, 2) |->
    $past(hsync_o, 6))
    else $error("horizontal sync shorter than a character");
endmodule : ccp_crt_checker
bind ccp_crt_core ccp_crt_checker chk_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .phi2_i(phi2_i), .cs_n_i(cs_n_i), .register_select_i(register_select_i), .rw_i(rw_i),
  .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_o(host_data_lines_oe_o),
  .character_clock_i(character_clock_i), .scan_reset_n_i(scan_reset_n_i),
  .hsync_o(hsync_o), .vsync_o(vsync_o), .disp_en_o(disp_en_o), .cursor_o(cursor_o),
  .video_mem_addr_o(video_mem_addr_o), .raster_line_addr_o(raster_line_addr_o));

// *** sim/ccp_host_bfm.sv ***
// host processor bus model issuing register transfers
`timescale 1ns/10ps
module ccp_host_bfm (
  input wire logic ref_clk_i, // clk
  output logic phi2_o, // bus clk
  output logic cs_n_o, // select
  output logic rs_o, // rs
  output logic rw_o, // dir
  output logic [7:0] data_o, // host data
  input wire logic [7:0] data_i, // device data
  input wire logic oe_i // device drives
);
  initial begin
    phi2_o = 1'b0;
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    rw_o = 1'b1;
    data_o = 8'h00;
  end
  // bus clock idles low between cycles, which the device must tolerate
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd,
                      output logic [7:0] rd, output logic drv);
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    rs_o <= rs;
    rw_o <= rw;
    data_o <= rw ? ~data_o : wd;
    repeat (5) @(posedge ref_clk_i);
    phi2_o <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    rd = data_i;
    drv = oe_i;
    phi2_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    // released lines show no stale value
    data_o <= ~data_o;
    repeat (3) @(posedge ref_clk_i);
  endtask : xfer
endmodule : ccp_host_bfm

// *** sim/testbench.sv ***
// self-checking bench for the timing controller
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i, rst_b_i, character_clock, scan_rst_n, pen, phi2, cs_n, rs, rw, oe, hs, vs, de, cur;
  logic [7:0] hd, dq, bus;
  logic [13:0] ma;
  logic [4:0] ra;
  int miscompares = 0;
  int checked = 0;
  int f_de [4];
  int f_cur [4];
  logic [15:0] prog [15] = '{16'h0009, 16'h0104, 16'h0206, 16'h0312, 16'h0403, 16'h0500,
    16'h0602, 16'h0703, 16'h0901, 16'h0A00, 16'h0B01, 16'h0C01, 16'h0D00, 16'h0E01, 16'h0F01};
  assign bus = oe ? dq : hd;
  ccp_host_bfm host (.ref_clk_i(ref_clk_i), .phi2_o(phi2), .cs_n_o(cs_n), .rs_o(rs),
    .rw_o(rw), .data_o(hd), .data_i(dq), .oe_i(oe));
  ccp_crt_core dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .phi2_i(phi2), .cs_n_i(cs_n),
    .register_select_i(rs), .rw_i(rw), .host_data_lines_i(bus), .host_data_lines_o(dq),
    .host_data_lines_oe_o(oe), .character_clock_i(character_clock), .scan_reset_n_i(scan_rst_n),
    .light_pen_strobe_i(pen), .hsync_o(hs), .vsync_o(vs), .disp_en_o(de), .cursor_o(cur),
    .video_mem_addr_o(ma), .raster_line_addr_o(ra));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    character_clock = 1'b0;
    #7;
    forever #80 character_clock = ~character_clock;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] d;
    logic e;
    host.xfer(1'b0, 1'b0, {3'h0, idx}, d, e);
    host.xfer(1'b1, 1'b0, v, d, e);
  endtask : wr
  // read status (rsel low) or a register; bit 8 of exp is the bus drive
  task automatic rdc(input logic rsel, input logic [4:0] idx, input logic [7:0] m,
                     input logic [8:0] exp);
    logic [7:0] d;
    logic e;
    if (rsel)
      host.xfer(1'b0, 1'b0, {3'h0, idx}, d, e);
    host.xfer(rsel, 1'b1, 8'h00, d, e);
    chk({15'h0000, e, d & m}, {15'h0000, exp});
  endtask : rdc
  task automatic t_regs;
    logic [7:0] d;
    logic e;
    rdc(1'b0, 5'h00, 8'hFF, 9'h100);
    wr(ccp_pkg::IDX_HTOT, 8'h09);
    rdc(1'b1, ccp_pkg::IDX_HTOT, 8'hFF, 9'h100);
    rdc(1'b1, ccp_pkg::IDX_DUMMY, 8'hFF, 9'h000);
    host.xfer(1'b0, 1'b0, 8'hEF, d, e);
    host.xfer(1'b1, 1'b0, 8'hA5, d, e);
    rdc(1'b1, ccp_pkg::IDX_CURL, 8'hFF, 9'h1A5);
    wr(ccp_pkg::IDX_CURH, 8'hFF);
    rdc(1'b1, ccp_pkg::IDX_CURH, 8'hFF, 9'h13F);
    $display("register test done");
  endtask : t_regs
  task automatic t_frame(input int n, input logic [7:0] mode);
    int nh = 0, nv = 0, nd = 0, nc = 0, col = 0, dl = 0;
    logic pde = 1'b0;
    logic [13:0] ea;
    wr(ccp_pkg::IDX_MODE, mode);
    @(posedge ref_clk_i);
    scan_rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    chk({1'b0, hs, vs, de, cur, ma, ra}, 24'h000000);
    @(posedge character_clock);
    @(posedge ref_clk_i);
    scan_rst_n <= 1'b1;
    @(posedge character_clock);
    f_de[n] = -1;
    f_cur[n] = -1;
    for (int k = 0; k < 80; k++) begin
      @(posedge character_clock);
      nh += hs;
      nv += vs;
      nd += de;
      nc += cur;
      if (de && f_de[n] < 0) f_de[n] = k;
      if (cur && f_cur[n] < 0) f_cur[n] = k;
      if (pde && !de) dl++;
      col = (pde && de) ? col + 1 : 0;
      ea = mode[2] ? {dl[6:1], col[7:0]} : 14'h0100 + 14'(dl / 2 * 4 + col);
      if (de && !mode[4]) chk({ma, ra}, {ea, 5'(dl % 2)});
      pde = de;
    end
    chk({nh[5:0], nv[5:0], nd[5:0], nc[5:0]}, {6'h10, 6'h0A, 6'h10, 6'h02});
    // early in the third row of the next frame the scan is blanking
    repeat (45) @(posedge character_clock);
    rdc(1'b0, 5'h00, 8'h20, 9'h120);
    $display("frame test %0d done", n);
  endtask : t_frame
  task automatic t_pen;
    @(posedge ref_clk_i);
    scan_rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    @(posedge character_clock);
    @(posedge ref_clk_i);
    scan_rst_n <= 1'b1;
    // pen rises just after the tick that moves the scan to the fourth character
    repeat (3) @(posedge character_clock);
    @(posedge ref_clk_i);
    pen <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    pen <= 1'b0;
    rdc(1'b0, 5'h00, 8'h40, 9'h140);
    rdc(1'b1, ccp_pkg::IDX_LPENH, 8'hFF, 9'h101);
    rdc(1'b1, ccp_pkg::IDX_LPENL, 8'hFF, 9'h105);
    rdc(1'b0, 5'h00, 8'h40, 9'h100);
    $display("pen test done");
  endtask : t_pen
  task automatic t_update;
    logic seen = 1'b0;
    wr(ccp_pkg::IDX_MODE, 8'h08);
    rdc(1'b1, ccp_pkg::IDX_DUMMY, 8'hFF, 9'h000);
    repeat (200) begin
      @(posedge ref_clk_i);
      seen |= ra[4];
    end
    chk({23'h000000, seen}, 24'h000001);
    rdc(1'b0, 5'h00, 8'h80, 9'h180);
    // leave transparent mode first, or the access re-arms a strobe that sets the flag again
    wr(ccp_pkg::IDX_MODE, 8'h00);
    wr(ccp_pkg::IDX_DUMMY, 8'h00);
    rdc(1'b0, 5'h00, 8'h80, 9'h100);
    $display("update test done");
  endtask : t_update
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    rst_b_i = 1'b0;
    scan_rst_n = 1'b0;
    pen = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_regs();
    foreach (prog[i]) wr(prog[i][12:8], prog[i][7:0]);
    t_frame(0, 8'h00);
    t_frame(1, 8'h04);
    t_frame(2, 8'h10);
    t_frame(3, 8'h20);
    chk(24'(f_de[2] - f_de[0]), 24'h000001);
    chk(24'(f_cur[3] - f_cur[0]), 24'h000001);
    t_pen();
    t_update();
    stop_test();
  end
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule : testbench
